// >>> design/gdp_params.svh
// Timing constants for the gate-drive host controller.
// Assumes a single 100 MHz core clock; all counts derive from the period.
`ifndef GDP_PARAMS_SVH
`define GDP_PARAMS_SVH

`define GDP_CLK_PERIOD_NS 10
// Least dead time between complementary commands of one phase
`define GDP_DEAD_TIME_NS 1500
`define GDP_DEAD_CYCLES ((`GDP_DEAD_TIME_NS + `GDP_CLK_PERIOD_NS - 1) / `GDP_CLK_PERIOD_NS)
// Least low time when this side pulls the fault line as a shutdown
`define GDP_PULL_TIME_NS 6000
`define GDP_PULL_CYCLES ((`GDP_PULL_TIME_NS + `GDP_CLK_PERIOD_NS - 1) / `GDP_CLK_PERIOD_NS)
// Least pause before motor commands resume after a fault stop
`define GDP_RESTART_WAIT_S 2
`define GDP_RESTART_CYCLES (`GDP_RESTART_WAIT_S * (1000000000 / `GDP_CLK_PERIOD_NS))
// Latest removal of commands after the fault line falls
`define GDP_REMOVE_TIME_NS 15000
`define GDP_REMOVE_CYCLES (`GDP_REMOVE_TIME_NS / `GDP_CLK_PERIOD_NS)

`endif

// >>> design/gdp_pkg.sv
// Types shared by the gate-drive host controller and its phase module.
// Assumes gdp_params.svh provides the timing counts.
package gdp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_PULL,
    ST_HALT,
    ST_WAIT
  } gdp_state_type;

  typedef struct packed {
    gdp_state_type state;
    logic [27:0] count;
    logic faultMeta;
    logic faultSync;
    logic limitMeta;
    logic limitSync;
    logic pullLow;
    logic faultLevel;
    logic hsShutdown;
    logic cmdEnable;
    logic faultSeen;
    logic running;
  } gdp_ctrl_type;

  typedef struct packed {
    logic highOn;
    logic lowOn;
    logic [7:0] gap;
  } gdp_phase_type;

endpackage

// >>> design/gdp_phase_deadtime.sv
// One phase of command generation with enforced dead time.
// Assumes enable and the wanted levels come from logic on core_clk.
`timescale 1ns/1ps
`include "gdp_params.svh"

module gdp_phase_deadtime #(
  parameter int DEAD_CYCLES = `GDP_DEAD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic wantHigh,
  input wire logic wantLow,
  output logic highCmd,
  output logic lowCmd
);

  gdp_pkg::gdp_phase_type phase_reg;
  gdp_pkg::gdp_phase_type phase_next;
  logic reqHigh;
  logic reqLow;

  // Both requested at once is treated as neither, never as shoot-through
  assign reqHigh = enable & wantHigh & ~wantLow;
  assign reqLow = enable & wantLow & ~wantHigh;

  always_comb
  begin
    phase_next = phase_reg;
    if (phase_reg.highOn && !reqHigh)
    begin
      phase_next.highOn = 1'b0;
      phase_next.gap = 8'(DEAD_CYCLES);
    end
    else if (phase_reg.lowOn && !reqLow)
    begin
      phase_next.lowOn = 1'b0;
      phase_next.gap = 8'(DEAD_CYCLES);
    end
    else if (phase_reg.gap != 8'h00)
    begin
      phase_next.gap = phase_reg.gap - 8'h01;
    end
    else if (reqHigh && !phase_reg.lowOn)
    begin
      phase_next.highOn = 1'b1;
    end
    else if (reqLow && !phase_reg.highOn)
    begin
      phase_next.lowOn = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
    end
  end

  assign highCmd = phase_reg.highOn;
  assign lowCmd = phase_reg.lowOn;

  // ****************************************
  // Checks
  // ****************************************
  localparam int DEAD_MIN = `GDP_DEAD_CYCLES;
  logic [7:0] offLen;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      offLen <= 8'hff;
    end
    else if (phase_reg.highOn || phase_reg.lowOn)
    begin
      offLen <= 8'h00;
    end
    else if (offLen != 8'hff)
    begin
      offLen <= offLen + 8'h01;
    end
  end

  a_no_overlap: assert property (@(posedge core_clk) disable iff (rst)
    !(highCmd && lowCmd))
    else $error("high and low command on together");

  a_dead_gap: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(highCmd) || $rose(lowCmd)) |-> $past(offLen) >= 8'(DEAD_MIN - 1))
    else $error("dead time too short before turn-on");

  a_disable_off: assert property (@(posedge core_clk) disable iff (rst)
    !enable |=> !highCmd && !lowCmd)
    else $error("command still on one cycle after disable");

endmodule // gdp_phase_deadtime

// >>> design/gdp_host_ctrl.sv
// Host controller driving a three-phase gate-drive device through its pins.
// Assumes fault line and current-limit pins are asynchronous; user inputs are on core_clk.
//
// Contract
// - Fault line is also a shutdown input; a pull low lasts 6 us or more.
// - Controller removes every command within 15 us after the fault line falls.
// - After a fault stop, controller waits at least 2 s before resuming.
// - Current-limit output may be routed to the high-side shutdown input.
// - Inverted fault line may be routed to the high-side shutdown input.
// - Controller inserts at least 1.5 us dead time between complementary commands.
`timescale 1ns/1ps
`include "gdp_params.svh"

module gdp_host_ctrl #(
  parameter int PHASES = 3,
  parameter int RESTART_CYCLES = `GDP_RESTART_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic runEnable,
  input wire logic [PHASES-1:0] pwmHigh,
  input wire logic [PHASES-1:0] pwmLow,
  input wire logic shutdownReq,
  input wire logic highSideOffReq,
  input wire logic routeLimitToShutdown,
  input wire logic routeFaultToShutdown,
  input wire logic faultClear,
  input wire logic fault_line_in,
  input wire logic current_limit_out,
  output logic [PHASES-1:0] high_side_cmd,
  output logic [PHASES-1:0] low_side_cmd,
  output logic high_side_shutdown_in,
  output logic fault_line_out,
  output logic fault_line_oe,
  output logic motorRunning,
  output logic faultSeen,
  output logic limitActive
);

  localparam logic [27:0] PULL_LAST = 28'(`GDP_PULL_CYCLES - 1);

  gdp_pkg::gdp_ctrl_type ctrl_reg;
  gdp_pkg::gdp_ctrl_type ctrl_next;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    ctrl_next = ctrl_reg;
    ctrl_next.faultMeta = fault_line_in;
    ctrl_next.faultSync = ctrl_reg.faultMeta;
    ctrl_next.limitMeta = current_limit_out;
    ctrl_next.limitSync = ctrl_reg.limitMeta;
    ctrl_next.faultLevel = 1'b0;
    case (ctrl_reg.state)
      gdp_pkg::ST_IDLE:
      begin
        ctrl_next.count = '0;
        if (shutdownReq)
        begin
          ctrl_next.state = gdp_pkg::ST_PULL;
        end
        else if (runEnable && ctrl_reg.faultSync)
        begin
          ctrl_next.state = gdp_pkg::ST_RUN;
        end
      end
      gdp_pkg::ST_RUN:
      begin
        if (shutdownReq)
        begin
          ctrl_next.state = gdp_pkg::ST_PULL;
          ctrl_next.count = '0;
        end
        else if (!ctrl_reg.faultSync)
        begin
          ctrl_next.state = gdp_pkg::ST_HALT;
        end
        else if (!runEnable)
        begin
          ctrl_next.state = gdp_pkg::ST_IDLE;
        end
      end
      gdp_pkg::ST_PULL:
      begin
        // Our own pull reads back as a fault, so it also earns the restart pause
        if (ctrl_reg.count == PULL_LAST)
        begin
          ctrl_next.state = gdp_pkg::ST_HALT;
          ctrl_next.count = '0;
        end
        else
        begin
          ctrl_next.count = ctrl_reg.count + 28'h0000001;
        end
      end
      gdp_pkg::ST_HALT:
      begin
        // The device may hold the line for its trip hold time; wait it out
        ctrl_next.count = '0;
        if (ctrl_reg.faultSync)
        begin
          ctrl_next.state = gdp_pkg::ST_WAIT;
        end
      end
      gdp_pkg::ST_WAIT:
      begin
        if (!ctrl_reg.faultSync)
        begin
          ctrl_next.state = gdp_pkg::ST_HALT;
          ctrl_next.count = '0;
        end
        else if (ctrl_reg.count == 28'(RESTART_CYCLES - 1))
        begin
          ctrl_next.state = gdp_pkg::ST_IDLE;
          ctrl_next.count = '0;
        end
        else
        begin
          ctrl_next.count = ctrl_reg.count + 28'h0000001;
        end
      end
      default:
      begin
        ctrl_next.state = gdp_pkg::ST_IDLE;
        ctrl_next.count = '0;
      end
    endcase
    ctrl_next.pullLow = (ctrl_next.state == gdp_pkg::ST_PULL);
    ctrl_next.cmdEnable = (ctrl_next.state == gdp_pkg::ST_RUN);
    ctrl_next.running = (ctrl_next.state == gdp_pkg::ST_RUN);
    // Set wins over a clear in the same cycle
    ctrl_next.faultSeen = (ctrl_reg.faultSeen & ~faultClear) | ~ctrl_reg.faultSync;
    ctrl_next.hsShutdown = highSideOffReq
      | (routeLimitToShutdown & ctrl_reg.limitSync)
      | (routeFaultToShutdown & ~ctrl_reg.faultSync);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_reg <= '0;
      ctrl_reg.state <= gdp_pkg::ST_IDLE;
      ctrl_reg.faultMeta <= 1'b1;
      ctrl_reg.faultSync <= 1'b1;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************
  // Phase command generation
  // ****************************************
  genvar ph;
  generate
    for (ph = 0; ph < PHASES; ph++)
    begin : g_phase
      gdp_phase_deadtime u_phase (
        .core_clk(core_clk),
        .rst(rst),
        .enable(ctrl_reg.cmdEnable),
        .wantHigh(pwmHigh[ph]),
        .wantLow(pwmLow[ph]),
        .highCmd(high_side_cmd[ph]),
        .lowCmd(low_side_cmd[ph])
      );
    end
  endgenerate

  assign high_side_shutdown_in = ctrl_reg.hsShutdown;
  assign fault_line_out = ctrl_reg.faultLevel;
  assign fault_line_oe = ctrl_reg.pullLow;
  assign motorRunning = ctrl_reg.running;
  assign faultSeen = ctrl_reg.faultSeen;
  assign limitActive = ctrl_reg.limitSync;

  // ****************************************
  // Checks
  // ****************************************
  localparam int PULL_MIN = `GDP_PULL_CYCLES;
  logic [11:0] pullLen;
  logic [27:0] sinceLineHigh;
  logic allOff;

  assign allOff = (high_side_cmd == '0) && (low_side_cmd == '0);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pullLen <= 12'h000;
    end
    else if (fault_line_oe)
    begin
      pullLen <= pullLen + 12'h001;
    end
    else
    begin
      pullLen <= 12'h000;
    end
  end

  // Cycles since the synced fault line was last seen low; saturates so the first start passes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sinceLineHigh <= '1;
    end
    else if (!ctrl_reg.faultSync)
    begin
      sinceLineHigh <= '0;
    end
    else if (sinceLineHigh != '1)
    begin
      sinceLineHigh <= sinceLineHigh + 28'h0000001;
    end
  end

  sequence s_fault_seen;
    ctrl_reg.state == gdp_pkg::ST_RUN && !ctrl_reg.faultSync && !shutdownReq;
  endsequence

  sequence s_cmds_gone;
    ##[1:3] allOff;
  endsequence

  a_fault_removal: assert property (@(posedge core_clk) disable iff (rst)
    s_fault_seen |-> s_cmds_gone)
    else $error("commands not removed after fault line fell");

  a_pull_width: assert property (@(posedge core_clk) disable iff (rst)
    $fell(fault_line_oe) |-> pullLen == 12'(PULL_MIN))
    else $error("fault line pull of wrong length");

  a_pull_level: assert property (@(posedge core_clk) disable iff (rst)
    fault_line_oe |-> !fault_line_out ##1 allOff)
    else $error("fault pull without low level or with commands on");

  a_restart_wait: assert property (@(posedge core_clk) disable iff (rst)
    $rose(motorRunning) |-> sinceLineHigh >= 28'(RESTART_CYCLES))
    else $error("motor restarted before the pause ran out");

  a_wait_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl_reg.state == gdp_pkg::ST_WAIT)[*3] |-> allOff && !motorRunning)
    else $error("commands active during restart pause");

  a_limit_route: assert property (@(posedge core_clk) disable iff (rst)
    (routeLimitToShutdown && limitActive) |=> high_side_shutdown_in)
    else $error("current limit not routed to high-side shutdown");

  a_fault_route: assert property (@(posedge core_clk) disable iff (rst)
    (routeFaultToShutdown && $past(fault_line_in, 2) == 1'b0 && $past(fault_line_in, 3) == 1'b0)
      |-> ##1 high_side_shutdown_in)
    else $error("fault line not routed to high-side shutdown");

endmodule // gdp_host_ctrl

// >>> verif/gdp_device_model.sv
// Behavioural model of the three-phase gate-drive device facing the host controller.
// Assumes times in ns and comparator flags driven directly by the bench.
`timescale 1ns/1ps

module gdp_device_model #(
  parameter int HOLD_NS = 25000,
  parameter int SD_FILTER_NS = 3300
) (
  input wire logic tripIn,
  input wire logic limitIn,
  input wire logic thermalIn,
  input wire logic supplyLowIn,
  input wire logic hostPull,
  input wire logic [2:0] highCmd,
  input wire logic [2:0] lowCmd,
  input wire logic hsShutdown,
  input wire logic [2:0] bootLowIn,
  output logic limitOut,
  output logic faultLine,
  output logic [2:0] highGate,
  output logic [2:0] lowGate
);
  logic tripHold = 1'b0;
  logic sdFilt = 1'b0;
  logic [2:0] hsLatch = 3'h0;
  logic [2:0] prevCmd = 3'h0;
  logic tripActive;
  logic [2:0] bootLock = 3'h0;

  // ****************************************
  // Protection flags
  // ****************************************
  // Trip stays active for the hold time even if the sense input drops
  always @(posedge tripIn)
  begin
    tripHold = 1'b1;
    #(HOLD_NS) tripHold = 1'b0;
  end
  assign tripActive = tripIn | tripHold;
  assign limitOut = limitIn | tripActive;
  // Pulled-up open drain; bootstrap lockout never pulls it
  assign faultLine = ~(hostPull | tripActive | thermalIn | supplyLowIn);

  // ****************************************
  // Gate drive
  // ****************************************
  // Short shutdown pulses are swallowed by the filter delay
  always @(hsShutdown)
  begin
    if (!hsShutdown)
      sdFilt = 1'b0;
    else
      #(SD_FILTER_NS) sdFilt = hsShutdown;
  end
  // Per-phase bootstrap lockout; short dips die in the filter delay
  for (genvar i = 0; i < 3; i++)
  begin : g_boot
    always @(bootLowIn[i])
    begin
      if (!bootLowIn[i])
        bootLock[i] = 1'b0;
      else
        #(3000) bootLock[i] = bootLowIn[i];
    end
  end
  always @(highCmd or sdFilt or bootLock)
  begin
    hsLatch = (hsLatch | (highCmd & ~prevCmd)) & highCmd;
    if (sdFilt)
      hsLatch = 3'h0;
    // Cleared latch waits for a fresh rising command after release
    hsLatch = hsLatch & ~bootLock;
    prevCmd = highCmd;
  end
  assign highGate = hsLatch;
  assign lowGate = lowCmd & {3{faultLine}};
endmodule // gdp_device_model

// >>> verif/testbench.sv
// Self-checking bench for the gate-drive host controller against the device model.
// Assumes gdp_params.svh is on the include path; restart pause shortened to 50 cycles.
`timescale 1ns/1ps

`define GDP_CHECK(act, exp) \
  begin total_checks++; if ((act) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED at %0t: outputs %h expected %h", $time, act, exp); end end

module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic runEnable = 1'b0;
  logic [2:0] pwmHigh = 3'h0;
  logic [2:0] pwmLow = 3'h0;
  logic shutdownReq = 1'b0;
  logic highSideOffReq = 1'b0;
  logic routeLimitToShutdown = 1'b0;
  logic routeFaultToShutdown = 1'b0;
  logic faultClear = 1'b0;
  logic tripIn = 1'b0;
  logic limitIn = 1'b0;
  logic faultLine, limitOut, hsShutdown, lineOe, lineOut, running, seen, limitSeen;
  logic [2:0] highCmd, lowCmd, highGate, lowGate, r;
  logic [10:0] snap;
  logic [10:0] expQ[$];
  event sampleEv;
  int n_errors = 0;
  int total_checks = 0;

  assign snap = {highCmd, lowCmd, hsShutdown, lineOe, running, seen, limitSeen};

  gdp_host_ctrl #(.PHASES(3), .RESTART_CYCLES(50)) gdp_host_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .runEnable(runEnable), .pwmHigh(pwmHigh),
    .pwmLow(pwmLow), .shutdownReq(shutdownReq), .highSideOffReq(highSideOffReq),
    .routeLimitToShutdown(routeLimitToShutdown), .routeFaultToShutdown(routeFaultToShutdown),
    .faultClear(faultClear), .fault_line_in(faultLine), .current_limit_out(limitOut),
    .high_side_cmd(highCmd), .low_side_cmd(lowCmd), .high_side_shutdown_in(hsShutdown),
    .fault_line_out(lineOut), .fault_line_oe(lineOe), .motorRunning(running),
    .faultSeen(seen), .limitActive(limitSeen));

  gdp_device_model gdp_device_model_inst (
    .tripIn(tripIn), .limitIn(limitIn), .thermalIn(1'b0), .supplyLowIn(1'b0),
    .hostPull(lineOe & ~lineOut), .highCmd(highCmd), .lowCmd(lowCmd),
    .hsShutdown(hsShutdown), .bootLowIn(3'h0), .limitOut(limitOut), .faultLine(faultLine),
    .highGate(highGate), .lowGate(lowGate));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic expect_snap(input logic [10:0] v);
    expQ.push_back(v);
    ->sampleEv;
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Output monitor
  // ****************************************
  initial
  begin
    logic [10:0] e;
    forever
    begin
      @(sampleEv);
      while (expQ.size() > 0)
      begin
        e = expQ.pop_front();
        `GDP_CHECK(snap, e)
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(77));
    cyc(12);
    rst = 1'b0;
    cyc(2);
    expect_snap(11'h000);
    limitIn = 1'b1;
    routeLimitToShutdown = 1'b1;
    cyc(4);
    expect_snap({6'h00, 5'h11});
    limitIn = 1'b0;
    routeLimitToShutdown = 1'b0;
    highSideOffReq = 1'b1;
    cyc(4);
    expect_snap({6'h00, 5'h10});
    highSideOffReq = 1'b0;
    r = 3'($urandom());
    pwmHigh = r;
    pwmLow = ~r;
    runEnable = 1'b1;
    cyc(6);
    expect_snap({r, ~r, 5'h04});
    // Every phase swaps sides, so all must sit off through the gap
    pwmHigh = ~r;
    pwmLow = r;
    cyc(100);
    expect_snap({6'h00, 5'h04});
    cyc(60);
    expect_snap({~r, r, 5'h04});
    routeFaultToShutdown = 1'b1;
    tripIn = 1'b1;
    cyc(10);
    expect_snap({6'h00, 5'h13});
    cyc(50);
    tripIn = 1'b0;
    cyc(1000);
    expect_snap({6'h00, 5'h13});
    @(posedge faultLine);
    cyc(1);
    routeFaultToShutdown = 1'b0;
    cyc(20);
    expect_snap({6'h00, 5'h02});
    cyc(70);
    expect_snap({~r, r, 5'h06});
    faultClear = 1'b1;
    cyc(1);
    faultClear = 1'b0;
    cyc(2);
    expect_snap({~r, r, 5'h04});
    shutdownReq = 1'b1;
    @(posedge core_clk);
    cyc(1);
    shutdownReq = 1'b0;
    repeat (599) @(posedge core_clk);
    cyc(1);
    expect_snap({6'h00, 5'h0a});
    cyc(1);
    expect_snap({6'h00, 5'h02});
    cyc(2);
    complete_run();
  end

  // Run takes about 3500 cycles; cut off far beyond that
  initial
  begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule // testbench
